//--- design/rtss_consts.vh
// constants for the reset and test strap sampler
`ifndef RTSS_CONSTS_VH
`define RTSS_CONSTS_VH
`define RTSS_CLK_PERIOD_PS   8000
`define RTSS_SAMPLE_DELAY_PS 1500000
`define RTSS_SAMPLE_CYCLES   ((`RTSS_SAMPLE_DELAY_PS + `RTSS_CLK_PERIOD_PS - 1) / `RTSS_CLK_PERIOD_PS)
`define RTSS_TP_WIDTH        8
`define RTSS_CNT_WIDTH       8
`define RTSS_CFG_CYCLES      16
`define RTSS_ST_HOLD         2'h0
`define RTSS_ST_WAIT         2'h1
`define RTSS_ST_CFG          2'h2
`define RTSS_ST_RUN          2'h3
`endif

//--- design/rtss_sync.v
// three-flop synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`default_nettype none
module rtss_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)(
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] s1;
   reg [WIDTH-1:0] s2;
   reg [WIDTH-1:0] s3;
   genvar i;
   // ************************************************
   // per-bit chain; s1 feeds only s2
   // ************************************************
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always @(posedge clk)
         begin
            if (rst)
            begin
               s1[i]   <= INIT[i];
               s2[i]   <= INIT[i];
               s3[i]   <= INIT[i];
               dout[i] <= INIT[i];
            end
            else
            begin
               s1[i] <= din[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               // a change counts only once second and third agree
               if (s2[i] == s3[i])
                  dout[i] <= s3[i];
            end
         end
      end
   endgenerate
endmodule // rtss_sync
`default_nettype wire

//--- design/rtss_top.v
// reset handling and test-point strap sampling top level
//
// Behaviour
// [RULE_01] configuration sequence starts on low-to-high edge of the reset pin
// [RULE_02] while reset pin is low, every output stays inactive
// [RULE_03] reset driver releases pin only after supplies and clocks are stable
// [RULE_04] all eight test-point pins are undriven while reset pin is low
// [RULE_05] about 1.5 us after release, test points are sampled as mode selection
// [RULE_06] after sampling, test points become driven test outputs
// [RULE_07] any high sampled bit selects test mode; all low means normal
// [RULE_08] sampled selection is held until the reset pin is asserted again
`timescale 1ns/1ps
`default_nettype none
`include "rtss_consts.vh"
module rtss_top #(
   parameter TP_WIDTH   = `RTSS_TP_WIDTH,
   parameter CFG_CYCLES = `RTSS_CFG_CYCLES
)(
   input  wire                CLK,
   input  wire                RST,
   input  wire                POWER_ON_RESET_LOW,
   input  wire [TP_WIDTH-1:0] TEST_POINT_PIN_IN,
   input  wire [TP_WIDTH-1:0] TEST_POINT_OUT_DATA,
   output reg  [TP_WIDTH-1:0] TEST_POINT_PIN_OUT,
   output reg  [TP_WIDTH-1:0] TEST_POINT_PIN_OE,
   output reg  [TP_WIDTH-1:0] TEST_MODE_SEL,
   output reg                 TEST_MODE_ACTIVE,
   output reg                 CONFIG_START,
   output reg                 CONFIG_BUSY,
   output reg                 DEVICE_READY
);
   // ************************************************
   // timing
   // ************************************************
   // the wait rounds the sample delay up to whole clocks; both counts are
   // cut to the counter width on purpose, so a faster clock or a longer
   // config phase needs a wider counter in the constants header
   localparam integer SAMPLE_CYCLES_I = `RTSS_SAMPLE_CYCLES;
   localparam integer CFG_CYCLES_I    = CFG_CYCLES;
   localparam [`RTSS_CNT_WIDTH-1:0] SAMPLE_CNT = SAMPLE_CYCLES_I[`RTSS_CNT_WIDTH-1:0];
   localparam [`RTSS_CNT_WIDTH-1:0] CFG_CNT    = CFG_CYCLES_I[`RTSS_CNT_WIDTH-1:0];
   localparam [1:0] ST_HOLD = `RTSS_ST_HOLD;
   localparam [1:0] ST_WAIT = `RTSS_ST_WAIT;
   localparam [1:0] ST_CFG  = `RTSS_ST_CFG;
   localparam [1:0] ST_RUN  = `RTSS_ST_RUN;

   wire                       rst_pin;
   wire [TP_WIDTH-1:0]        tp_in;
   reg                        rst_pin_d;
   reg  [1:0]                 state;
   reg  [1:0]                 next_state;
   reg  [`RTSS_CNT_WIDTH-1:0] cnt;
   reg  [`RTSS_CNT_WIDTH-1:0] next_cnt;
   wire                       rise;
   wire                       sample_now;
   wire                       drive_pins;

   // ************************************************
   // pin synchronisers
   // ************************************************
   // reset pin comes up low so the block starts inactive
   rtss_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_rst (
      .clk  (CLK),
      .rst  (RST),
      .din  (POWER_ON_RESET_LOW),
      .dout (rst_pin)
   );
   // test points idle low thanks to the weak pulldown
   rtss_sync #(.WIDTH(TP_WIDTH), .INIT({TP_WIDTH{1'b0}})) u_sync_tp (
      .clk  (CLK),
      .rst  (RST),
      .din  (TEST_POINT_PIN_IN),
      .dout (tp_in)
   );

   // edge detect on filtered reset pin
   always @(posedge CLK)
   begin
      if (RST)
         rst_pin_d <= 1'b0;
      else
         rst_pin_d <= rst_pin;
   end
   assign rise       = rst_pin & ~rst_pin_d;                 // [RULE_01]
   // sync latency adds a few cycles to the delay; well inside "about"
   assign sample_now = (state == ST_WAIT) && (cnt == SAMPLE_CNT - 8'h01);

   // ************************************************
   // sequencing state machine
   // ************************************************
   // relies on the driver releasing the pin only with clocks stable [RULE_03]
   always @*
   begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         ST_HOLD:
         begin
            next_cnt = 8'h00;
            if (rise)
               next_state = ST_WAIT;                         // [RULE_01]
         end
         ST_WAIT:
         begin
            next_cnt = cnt + 8'h01;
            if (sample_now)
            begin
               next_state = ST_CFG;                          // [RULE_05]
               next_cnt   = 8'h00;
            end
         end
         ST_CFG:
         begin
            next_cnt = cnt + 8'h01;
            if (cnt == CFG_CNT - 8'h01)
               next_state = ST_RUN;
         end
         ST_RUN:
            next_cnt = 8'h00;
         default:
         begin
            next_state = ST_HOLD;
            next_cnt   = 8'h00;
         end
      endcase
      // a reassertion at any point drops everything
      if (!rst_pin)
      begin
         next_state = ST_HOLD;                               // [RULE_02]
         next_cnt   = 8'h00;
      end
   end

   always @(posedge CLK)
   begin
      if (RST)
      begin
         state <= ST_HOLD;
         cnt   <= 8'h00;
      end
      else
      begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   // ************************************************
   // strap latch and pin drive
   // ************************************************
   // pins drive only once the selection has been captured; deciding on
   // next_state lets the drive start on the very edge that takes the strap
   assign drive_pins = (next_state == ST_CFG) || (next_state == ST_RUN);

   // the strap is taken once per release and then frozen, so a later
   // change on a test point cannot alter the selected mode
   always @(posedge CLK)
   begin
      if (RST)
      begin
         TEST_MODE_SEL    <= {TP_WIDTH{1'b0}};
         TEST_MODE_ACTIVE <= 1'b0;
      end
      else if (next_state == ST_HOLD)
      begin
         TEST_MODE_SEL    <= {TP_WIDTH{1'b0}};               // [RULE_08]
         TEST_MODE_ACTIVE <= 1'b0;                           // [RULE_02]
      end
      else if (sample_now)
      begin
         TEST_MODE_SEL    <= tp_in;                          // [RULE_05]
         TEST_MODE_ACTIVE <= |tp_in;                         // [RULE_07]
      end
   end

   // pins float while reset is held and during the wait before sampling
   always @(posedge CLK)
   begin
      if (RST)
      begin
         TEST_POINT_PIN_OE  <= {TP_WIDTH{1'b0}};
         TEST_POINT_PIN_OUT <= {TP_WIDTH{1'b0}};
      end
      else if (drive_pins)
      begin
         TEST_POINT_PIN_OE  <= {TP_WIDTH{1'b1}};             // [RULE_06]
         TEST_POINT_PIN_OUT <= TEST_POINT_OUT_DATA;
      end
      else
      begin
         // value forced low too, so a released pin carries no stale data
         TEST_POINT_PIN_OE  <= {TP_WIDTH{1'b0}};             // [RULE_04]
         TEST_POINT_PIN_OUT <= {TP_WIDTH{1'b0}};
      end
   end

   // ************************************************
   // status outputs
   // ************************************************
   // start is a single-cycle pulse; busy spans the wait and the config phase
   always @(posedge CLK)
   begin
      if (RST)
      begin
         CONFIG_START <= 1'b0;
         CONFIG_BUSY  <= 1'b0;
         DEVICE_READY <= 1'b0;
      end
      else if (next_state == ST_HOLD)
      begin
         CONFIG_START <= 1'b0;                               // [RULE_02]
         CONFIG_BUSY  <= 1'b0;
         DEVICE_READY <= 1'b0;
      end
      else
      begin
         CONFIG_START <= rise;                               // [RULE_01]
         CONFIG_BUSY  <= (next_state == ST_WAIT) || (next_state == ST_CFG);
         DEVICE_READY <= (next_state == ST_RUN);
      end
   end
endmodule // rtss_top
`default_nettype wire

//--- test/rtss_pmic_model.sv
// power-management partner model: drives the reset pin and the strap levels
`timescale 1ns/1ps
`default_nettype none
module rtss_pmic_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] strap,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   output logic            por_n,
   output logic [7:0]      pin_in
);
   int unsigned settle = 0;
   // hold reset until the clock has run a while, so supplies count as settled
   always @(posedge clk)
   begin
      settle <= go ? settle + 1 : 0;
      por_n  <= go && settle > 8;
   end
   // device drive wins; otherwise the board strap, whatever level the bench sets on strap
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & strap);
endmodule // rtss_pmic_model
`default_nettype wire

//--- test/rtss_top_asserts.sv
// concurrent checks on the ports of the sampler top level
`timescale 1ns/1ps
`default_nettype none
module rtss_top_asserts #(
   parameter TP_WIDTH   = 8,
   parameter CFG_CYCLES = 16
)(
   input wire logic                CLK,
   input wire logic                RST,
   input wire logic                POWER_ON_RESET_LOW,
   input wire logic [TP_WIDTH-1:0] TEST_POINT_OUT_DATA,
   input wire logic [TP_WIDTH-1:0] TEST_POINT_PIN_OUT,
   input wire logic [TP_WIDTH-1:0] TEST_POINT_PIN_OE,
   input wire logic [TP_WIDTH-1:0] TEST_MODE_SEL,
   input wire logic                TEST_MODE_ACTIVE,
   input wire logic                CONFIG_START,
   input wire logic                CONFIG_BUSY,
   input wire logic                DEVICE_READY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // pin low long enough to pass the synchroniser and filter
   sequence s_low;
      !POWER_ON_RESET_LOW [*6];
   endsequence
   // strap taken: pins still floating, then all of them driven a cycle later
   sequence s_strap_taken;
      TEST_POINT_PIN_OE == 0 ##1 &TEST_POINT_PIN_OE;
   endsequence
   a_start_pulse: assert property (CONFIG_START |=> !CONFIG_START && CONFIG_BUSY)
      else $error("start pulse wrong");
   a_hold_quiet: assert property (s_low |-> !(CONFIG_START || CONFIG_BUSY || DEVICE_READY))
      else $error("status active in reset");
   a_pins_float: assert property (s_low |-> TEST_POINT_PIN_OE == 0 && TEST_POINT_PIN_OUT == 0)
      else $error("test pins driven in reset");
   a_sample_time: assert property (disable iff (RST || !POWER_ON_RESET_LOW)
      CONFIG_START |-> ##187 s_strap_taken) else $error("sample time wrong");
   a_drive_data: assert property (|TEST_POINT_PIN_OE |-> TEST_POINT_PIN_OUT == $past(TEST_POINT_OUT_DATA))
      else $error("driven data wrong");
   a_mode_flag: assert property (TEST_MODE_ACTIVE == |TEST_MODE_SEL)
      else $error("mode flag wrong");
   a_sel_held: assert property (|TEST_POINT_PIN_OE ##1 |TEST_POINT_PIN_OE |-> $stable(TEST_MODE_SEL))
      else $error("selection changed");
endmodule // rtss_top_asserts
bind rtss_top rtss_top_asserts #(.TP_WIDTH(TP_WIDTH), .CFG_CYCLES(CFG_CYCLES)) i_chk (.CLK, .RST,
   .POWER_ON_RESET_LOW, .TEST_POINT_OUT_DATA, .TEST_POINT_PIN_OUT, .TEST_POINT_PIN_OE, .TEST_MODE_SEL,
   .TEST_MODE_ACTIVE, .CONFIG_START, .CONFIG_BUSY, .DEVICE_READY);
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the reset and strap sampler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       CLK = 0, RST = 1, go = 0, por_n, act, start, busy, rdy;
   logic [7:0] strap = 0, odata = 8'h3c, pin_in, pin_out, pin_oe, sel;
   logic [7:0] pats [4] = '{8'h00, 8'h01, 8'h80, 8'ha5};
   int         bad_count = 0, tests_run = 0;
   always #4 CLK = ~CLK;
   rtss_top i_dut (.CLK(CLK), .RST(RST), .POWER_ON_RESET_LOW(por_n), .TEST_POINT_PIN_IN(pin_in),
      .TEST_POINT_OUT_DATA(odata), .TEST_POINT_PIN_OUT(pin_out), .TEST_POINT_PIN_OE(pin_oe), .TEST_MODE_SEL(sel),
      .TEST_MODE_ACTIVE(act), .CONFIG_START(start), .CONFIG_BUSY(busy), .DEVICE_READY(rdy));
   rtss_pmic_model i_pmic (.clk(CLK), .go(go), .strap(strap), .pin_out(pin_out), .pin_oe(pin_oe),
      .por_n(por_n), .pin_in(pin_in));
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // inputs always change 1 ns after an edge, clear of sampling
   task automatic tick(int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // reset pin dropped while the sample wait is running
   task automatic t_abort;
      int n = 0;
      go = 1;
      while (start !== 1'b1 && n++ < 100) tick(1);
      tick(50);
      go = 0;
      tick(10);
      chk("status abort", {4'h0, start, busy, rdy, act}, 8'h00);
      chk("oe abort", pin_oe, 8'h00);
      chk("sel abort", sel, 8'h00);
   endtask
   // full power-up with one strap pattern
   task automatic t_boot(logic [7:0] s);
      int n = 0;
      strap = s;
      go = 0;
      tick(20);
      chk("oe reset", pin_oe, 8'h00);
      go = 1;
      while (start !== 1'b1 && n++ < 100) tick(1);
      chk("start", {7'h0, start}, 8'h01);
      chk("busy", {7'h0, busy}, 8'h01);
      n = 0;
      while (pin_oe === 8'h00 && n++ < 300) tick(1);
      chk("sample delay", 8'(n), 8'hbc);
      chk("sel", sel, s);
      chk("act", {7'h0, act}, {7'h0, |s});
      chk("oe", pin_oe, 8'hff);
      chk("out", pin_out, odata);
      strap = ~s;
      odata = ~odata;
      tick(20);
      chk("sel held", sel, s);
      chk("out new", pin_out, odata);
      chk("ready", {7'h0, rdy}, 8'h01);
      chk("busy done", {7'h0, busy}, 8'h00);
   endtask
   initial
   begin
      tick(16);
      RST = 0;
      t_abort();
      foreach (pats[i]) t_boot(pats[i]);
      report_and_stop();
   end
   // whole run needs about 1060 cycles
   initial
   begin
      #40000;
      bad_count++;
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
